// >>> rtl/dspw_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts for the dual-slope PWM timer
// Assumes: Included by bare name from the modules and the bench
// Notes:   Definitions only
`ifndef DSPW_DEFINES_SVH
`define DSPW_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DSPW_ADDR_CTRL_A    4'h0
`define DSPW_ADDR_CTRL_B    4'h1
`define DSPW_ADDR_CNT_LO    4'h2
`define DSPW_ADDR_CNT_HI    4'h3
`define DSPW_ADDR_CMPA_LO   4'h4
`define DSPW_ADDR_CMPA_HI   4'h5
`define DSPW_ADDR_CMPB_LO   4'h6
`define DSPW_ADDR_CMPB_HI   4'h7
`define DSPW_ADDR_CAP_LO    4'h8
`define DSPW_ADDR_CAP_HI    4'h9
`define DSPW_ADDR_FLAGS     4'hA

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DSPW_CTRLA_MODEA_HI 7
`define DSPW_CTRLA_MODEA_LO 6
`define DSPW_CTRLA_MODEB_HI 5
`define DSPW_CTRLA_MODEB_LO 4
`define DSPW_CTRLA_FORCEA   3
`define DSPW_CTRLA_FORCEB   2
`define DSPW_CTRLB_WGM_HI   4
`define DSPW_CTRLB_WGM_LO   3
`define DSPW_FLAG_OVF       0
`define DSPW_FLAG_CMPA      1
`define DSPW_FLAG_CMPB      2
`define DSPW_FLAG_CAP       3

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define DSPW_CTRL_A_RESET   8'h00
`define DSPW_CTRL_B_RESET   8'h00
`define DSPW_WORD_RESET     16'h0000
`define DSPW_BOTTOM         16'h0000
`define DSPW_MAX            16'hFFFF
`define DSPW_TOP_8BIT       16'h00FF
`define DSPW_TOP_9BIT       16'h01FF
`define DSPW_TOP_10BIT      16'h03FF
`define DSPW_DIV_8          10'd7
`define DSPW_DIV_64         10'd63
`define DSPW_DIV_256        10'd255
`define DSPW_DIV_1024       10'd1023

`endif

// >>> rtl/dspw_pkg.sv
// Purpose: Types for the dual-slope PWM timer
// Assumes: Defines header holds the numbers
// Notes:   Types only
package dspw_pkg;
	typedef logic [15:0] dspw_word_t;
	typedef logic [3:0]  dspw_wgm_t;
	typedef logic [1:0]  dspw_com_t;
	typedef enum logic [1:0] {
		DSPW_KIND_NONPWM,
		DSPW_KIND_FAST,
		DSPW_KIND_DUAL
	} dspw_kind_e;
endpackage : dspw_pkg

// >>> rtl/dspw_event_if.sv
// Purpose: Counter events passed from the counter core to each output channel
// Assumes: Single clock domain
// Notes:   Pulses are one clk cycle, valid only on a tick
`timescale 1ns/1ps
`default_nettype none
interface dspw_event_if;
	import dspw_pkg::*;
	dspw_word_t count;
	dspw_word_t top;
	logic       tick;
	logic       at_top;
	logic       counting_up;
	dspw_kind_e kind;
	dspw_wgm_t  wgm;
	modport core (output count, top, tick, at_top, counting_up, kind, wgm);
	modport chan (input count, top, tick, at_top, counting_up, kind, wgm);
endinterface : dspw_event_if
`default_nettype wire

// >>> rtl/dspw_channel.sv
// Purpose: One compare channel: buffered compare value, match detect and output waveform
// Assumes: Counter events from the core over dspw_event_if
// Notes:   Toggle in mode 1 in PWM modes is granted by the top through toggle_ok
`timescale 1ns/1ps
`default_nettype none
`include "dspw_defines.svh"
module dspw_channel
	import dspw_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	dspw_event_if.chan      ev,
	input  wire dspw_com_t  mode,
	input  wire logic       toggle_ok,
	input  wire logic       buf_we,
	input  wire dspw_word_t buf_wdata,
	input  wire logic       load_now,
	input  wire logic       force_cmp,
	output dspw_word_t      compare,
	output logic            match,
	output logic            wave
);
	dspw_word_t next_compare;
	dspw_word_t cbuf;
	dspw_word_t next_cbuf;
	logic       next_wave;
	logic       hit;

	// ----------------------------------------
	// Compare buffer and active compare value
	// ----------------------------------------
	always_comb begin
		next_cbuf    = buf_we ? buf_wdata : cbuf;
		next_compare = compare;
		if (ev.kind == DSPW_KIND_NONPWM)
			next_compare = next_cbuf;
		else if (load_now)
			next_compare = cbuf;
	end

	// Match is taken on a tick so one event per counter value
	assign hit   = ev.tick && (ev.count == compare);
	assign match = hit;

	// ----------------------------------------
	// Waveform level
	// ----------------------------------------
	always_comb begin
		next_wave = wave;
		case (ev.kind)
			DSPW_KIND_NONPWM: begin
				if (hit || force_cmp) begin
					case (mode)
						2'd1:    next_wave = ~wave;
						2'd2:    next_wave = 1'b0;
						2'd3:    next_wave = 1'b1;
						default: next_wave = wave;
					endcase
				end
			end
			DSPW_KIND_FAST: begin
				if (mode == 2'd1 && toggle_ok && hit)
					next_wave = ~wave;
				else if (mode[1] && ev.tick && ev.at_top)
					next_wave = (mode == 2'd2);
				else if (mode[1] && hit && compare != ev.top)
					next_wave = (mode == 2'd3);
			end
			default: begin
				// Dual slope: BOTTOM counts as rising, TOP as falling, so extremes hold a level
				if (mode == 2'd1 && toggle_ok && hit)
					next_wave = ~wave;
				else if (mode[1] && hit)
					next_wave = ev.counting_up ? (mode == 2'd3) : (mode == 2'd2);
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cbuf    <= `DSPW_WORD_RESET;
			compare <= `DSPW_WORD_RESET;
			wave    <= 1'b0;
		end else begin
			cbuf    <= next_cbuf;
			compare <= next_compare;
			wave    <= next_wave;
		end
	end

	nonpwm_set_a: assert property (@(posedge clk) disable iff (!nrst)
		ev.kind == DSPW_KIND_NONPWM && mode == 2'd3 && (hit || force_cmp) |=> wave)
		else $error("non-pwm set on match missed");
	dual_up_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		ev.kind == DSPW_KIND_DUAL && mode == 2'd2 && hit && ev.counting_up |=> !wave)
		else $error("dual slope up match did not clear");
	fast_top_set_a: assert property (@(posedge clk) disable iff (!nrst)
		ev.kind == DSPW_KIND_FAST && mode == 2'd2 && ev.tick && ev.at_top |=> wave)
		else $error("fast pwm did not set at top");
endmodule : dspw_channel
`default_nettype wire

// >>> rtl/dspw_prescaler.sv
// Purpose: Timer tick from the I/O clock through a selectable divider
// Assumes: Same clock as the timer
// Notes:   Tick is a one-cycle enable, never a clock
`timescale 1ns/1ps
`default_nettype none
`include "dspw_defines.svh"
module dspw_prescaler (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic [2:0] clock_select,
	output logic            tick
);
	logic [9:0] div;
	logic [9:0] next_div;
	logic [9:0] limit;
	logic       next_tick;

	always_comb begin
		case (clock_select)
			3'd2:    limit = `DSPW_DIV_8;
			3'd3:    limit = `DSPW_DIV_64;
			3'd4:    limit = `DSPW_DIV_256;
			3'd5:    limit = `DSPW_DIV_1024;
			default: limit = 10'd0;
		endcase
		next_div  = (div >= limit) ? 10'd0 : div + 10'd1;
		// External clock sources are outside this block; they give no tick
		next_tick = (clock_select != 3'd0) && (clock_select < 3'd6) && (div >= limit);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div  <= 10'd0;
			tick <= 1'b0;
		end else begin
			div  <= next_div;
			tick <= next_tick;
		end
	end
endmodule : dspw_prescaler
`default_nettype wire

// >>> rtl/dspw_timer.sv
// Purpose: 16-bit timer with dual-slope, fast and non-PWM waveform generation on two outputs
// Assumes: Plain register port, read data one cycle after the read strobe; single clock
// Notes:   Prescaler tick is a clock enable inside the clk domain
`timescale 1ns/1ps
`default_nettype none
`include "dspw_defines.svh"
module dspw_timer
	import dspw_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic [7:0]      rdata,
	input  wire logic       pin_direction_a,
	input  wire logic       pin_direction_b,
	input  wire logic       port_data_a,
	input  wire logic       port_data_b,
	output logic            wave_out_a,
	output logic            wave_out_b,
	output logic            wave_oe_a,
	output logic            wave_oe_b
);
	dspw_event_if ev ();

	logic [7:0] timer_wave_control_a;
	logic [7:0] next_ctrl_a;
	logic [7:0] ctrl_b;
	logic [7:0] next_ctrl_b;
	dspw_word_t count_value;
	dspw_word_t next_count;
	dspw_word_t capture_top_value;
	dspw_word_t next_capture;
	logic       down;
	logic       next_down;
	logic [3:0] flags;
	logic [3:0] next_flags;
	logic [7:0] next_rdata;
	logic [7:0] temp_hi;
	logic [7:0] next_temp_hi;
	logic       next_out_a;
	logic       next_out_b;
	logic       next_oe_a;
	logic       next_oe_b;
	dspw_wgm_t  waveform_mode;
	dspw_com_t  output_mode_a;
	dspw_com_t  output_mode_b;
	dspw_word_t compare_a_value;
	dspw_word_t compare_b_value;
	dspw_word_t top;
	logic       tick;
	logic       at_top;
	logic       at_bottom;
	logic       match_a;
	logic       match_b;
	logic       wave_a;
	logic       wave_b;
	logic       bottom_load;
	logic       toggle_ok_a;
	dspw_kind_e kind;

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	assign waveform_mode = {ctrl_b[`DSPW_CTRLB_WGM_HI:`DSPW_CTRLB_WGM_LO], timer_wave_control_a[1:0]};
	assign output_mode_a = timer_wave_control_a[`DSPW_CTRLA_MODEA_HI:`DSPW_CTRLA_MODEA_LO];
	assign output_mode_b = timer_wave_control_a[`DSPW_CTRLA_MODEB_HI:`DSPW_CTRLA_MODEB_LO];

	always_comb begin
		case (waveform_mode)
			4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11: kind = DSPW_KIND_DUAL;
			4'd5, 4'd6, 4'd7, 4'd14, 4'd15:             kind = DSPW_KIND_FAST;
			default:                                    kind = DSPW_KIND_NONPWM;
		endcase
		case (waveform_mode)
			4'd1, 4'd5:          top = `DSPW_TOP_8BIT;
			4'd2, 4'd6:          top = `DSPW_TOP_9BIT;
			4'd3, 4'd7:          top = `DSPW_TOP_10BIT;
			4'd8, 4'd10, 4'd12, 4'd14: top = capture_top_value;
			4'd4, 4'd9, 4'd11, 4'd15:  top = compare_a_value;
			default:             top = `DSPW_MAX;
		endcase
	end

	assign at_top      = (count_value == top);
	assign at_bottom   = (count_value == `DSPW_BOTTOM);
	// Frequency-correct modes load at BOTTOM, all other PWM modes at TOP
	assign bottom_load = tick && ((waveform_mode == 4'd8 || waveform_mode == 4'd9) ? at_bottom : at_top);
	assign toggle_ok_a = (kind == DSPW_KIND_FAST) ? (waveform_mode == 4'd15)
		: (kind == DSPW_KIND_DUAL) ? (waveform_mode == 4'd9 || waveform_mode == 4'd14) : 1'b1;

	assign ev.count       = count_value;
	assign ev.top         = top;
	assign ev.tick        = tick;
	assign ev.at_top      = at_top;
	// Turning points take the direction the counter leaves in, so the extremes hold a level
	assign ev.counting_up = at_bottom || (!at_top && !down);
	assign ev.kind        = kind;
	assign ev.wgm         = waveform_mode;

	dspw_prescaler u_presc (
		.clk          (clk),
		.nrst         (nrst),
		.clock_select (ctrl_b[2:0]),
		.tick         (tick)
	);

	dspw_channel u_chan_a (
		.clk       (clk),
		.nrst      (nrst),
		.ev        (ev),
		.mode      (output_mode_a),
		.toggle_ok (toggle_ok_a),
		.buf_we    (wr && addr == `DSPW_ADDR_CMPA_LO),
		.buf_wdata ({temp_hi, wdata}),
		.load_now  (bottom_load),
		.force_cmp (wr && addr == `DSPW_ADDR_CTRL_A && wdata[`DSPW_CTRLA_FORCEA]),
		.compare   (compare_a_value),
		.match     (match_a),
		.wave      (wave_a)
	);

	dspw_channel u_chan_b (
		.clk       (clk),
		.nrst      (nrst),
		.ev        (ev),
		.mode      (output_mode_b),
		.toggle_ok (kind == DSPW_KIND_NONPWM),
		.buf_we    (wr && addr == `DSPW_ADDR_CMPB_LO),
		.buf_wdata ({temp_hi, wdata}),
		.load_now  (bottom_load),
		.force_cmp (wr && addr == `DSPW_ADDR_CTRL_A && wdata[`DSPW_CTRLA_FORCEB]),
		.compare   (compare_b_value),
		.match     (match_b),
		.wave      (wave_b)
	);

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	always_comb begin
		next_count = count_value;
		next_down  = down;
		if (wr && addr == `DSPW_ADDR_CNT_LO) begin
			next_count = {temp_hi, wdata};
		end else if (tick) begin
			if (kind == DSPW_KIND_DUAL) begin
				// Turn on TOP: count stands at TOP for this one tick
				if (at_top) begin
					next_down  = 1'b1;
					next_count = count_value - 16'h0001;
				end else if (at_bottom) begin
					next_down  = 1'b0;
					next_count = count_value + 16'h0001;
				end else begin
					next_count = down ? count_value - 16'h0001 : count_value + 16'h0001;
				end
			end else begin
				next_down  = 1'b0;
				next_count = (at_top && waveform_mode != 4'd0) ? `DSPW_BOTTOM : count_value + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Flags: hardware set wins over a software clear (write one to clear)
	// ----------------------------------------
	always_comb begin
		next_flags = flags;
		if (wr && addr == `DSPW_ADDR_FLAGS)
			next_flags = flags & ~wdata[3:0];
		if (match_a || (tick && at_top && top == compare_a_value && waveform_mode == 4'd9))
			next_flags[`DSPW_FLAG_CMPA] = 1'b1;
		if (match_b)
			next_flags[`DSPW_FLAG_CMPB] = 1'b1;
		if (tick && at_top && (waveform_mode == 4'd8 || waveform_mode == 4'd10
			|| waveform_mode == 4'd12 || waveform_mode == 4'd14))
			next_flags[`DSPW_FLAG_CAP] = 1'b1;
		if (tick && (kind == DSPW_KIND_DUAL ? at_bottom
			: (kind == DSPW_KIND_FAST ? at_top : count_value == `DSPW_MAX)))
			next_flags[`DSPW_FLAG_OVF] = 1'b1;
	end

	// ----------------------------------------
	// Register port and pin drive
	// ----------------------------------------
	always_comb begin
		next_ctrl_a  = timer_wave_control_a;
		next_ctrl_b  = ctrl_b;
		next_capture = capture_top_value;
		next_temp_hi = temp_hi;
		if (wr) begin
			if (addr == `DSPW_ADDR_CTRL_A)
				next_ctrl_a = {wdata[7:4], 2'b00, wdata[1:0]}; // force bits are strobes
			else if (addr == `DSPW_ADDR_CTRL_B)
				next_ctrl_b = {wdata[7:6], 1'b0, wdata[4:0]};
			else if (addr == `DSPW_ADDR_CAP_LO)
				next_capture = {temp_hi, wdata};
			else if (addr == `DSPW_ADDR_CNT_HI || addr == `DSPW_ADDR_CMPA_HI
				|| addr == `DSPW_ADDR_CMPB_HI || addr == `DSPW_ADDR_CAP_HI)
				next_temp_hi = wdata;
		end
		next_rdata = 8'h00;
		if (rd) begin
			if (addr == `DSPW_ADDR_CTRL_A)       next_rdata = timer_wave_control_a;
			else if (addr == `DSPW_ADDR_CTRL_B)  next_rdata = ctrl_b;
			else if (addr == `DSPW_ADDR_CNT_LO)  next_rdata = count_value[7:0];
			else if (addr == `DSPW_ADDR_CNT_HI)  next_rdata = count_value[15:8];
			else if (addr == `DSPW_ADDR_CMPA_LO) next_rdata = compare_a_value[7:0];
			else if (addr == `DSPW_ADDR_CMPA_HI) next_rdata = compare_a_value[15:8];
			else if (addr == `DSPW_ADDR_CMPB_LO) next_rdata = compare_b_value[7:0];
			else if (addr == `DSPW_ADDR_CMPB_HI) next_rdata = compare_b_value[15:8];
			else if (addr == `DSPW_ADDR_CAP_LO)  next_rdata = capture_top_value[7:0];
			else if (addr == `DSPW_ADDR_CAP_HI)  next_rdata = capture_top_value[15:8];
			else if (addr == `DSPW_ADDR_FLAGS)   next_rdata = {4'h0, flags};
		end
		// Nonzero mode takes the pin; mode 1 without toggle rights leaves it to the port
		next_oe_a  = pin_direction_a;
		next_oe_b  = pin_direction_b;
		next_out_a = (output_mode_a != 2'd0 && (output_mode_a != 2'd1 || toggle_ok_a))
			? wave_a : port_data_a;
		next_out_b = (output_mode_b != 2'd0 && (output_mode_b != 2'd1 || kind == DSPW_KIND_NONPWM))
			? wave_b : port_data_b;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			timer_wave_control_a <= `DSPW_CTRL_A_RESET;
			ctrl_b               <= `DSPW_CTRL_B_RESET;
			count_value          <= `DSPW_WORD_RESET;
			capture_top_value    <= `DSPW_WORD_RESET;
			down                 <= 1'b0;
			flags                <= 4'h0;
			temp_hi              <= 8'h00;
			rdata                <= 8'h00;
			wave_out_a           <= 1'b0;
			wave_out_b           <= 1'b0;
			wave_oe_a            <= 1'b0;
			wave_oe_b            <= 1'b0;
		end else begin
			timer_wave_control_a <= next_ctrl_a;
			ctrl_b               <= next_ctrl_b;
			count_value          <= next_count;
			capture_top_value    <= next_capture;
			down                 <= next_down;
			flags                <= next_flags;
			temp_hi              <= next_temp_hi;
			rdata                <= next_rdata;
			wave_out_a           <= next_out_a;
			wave_out_b           <= next_out_b;
			wave_oe_a            <= next_oe_a;
			wave_oe_b            <= next_oe_b;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	top_reverse_a: assert property (@(posedge clk) disable iff (!nrst)
		kind == DSPW_KIND_DUAL && tick && at_top && !(wr && addr == `DSPW_ADDR_CNT_LO)
		|=> down && count_value == $past(count_value) - 16'h0001) else $error("no reversal at top");
	bottom_ovf_a: assert property (@(posedge clk) disable iff (!nrst)
		kind == DSPW_KIND_DUAL && tick && at_bottom |=> flags[`DSPW_FLAG_OVF])
		else $error("overflow flag missing at bottom");
	cap_top_flag_a: assert property (@(posedge clk) disable iff (!nrst)
		waveform_mode == 4'd8 && tick && at_top |=> flags[`DSPW_FLAG_CAP])
		else $error("capture flag missing at top");
	cmp_b_flag_a: assert property (@(posedge clk) disable iff (!nrst)
		tick && count_value == compare_b_value |=> flags[`DSPW_FLAG_CMPB]) else $error("compare b flag missing");
	hold_steady_a: assert property (@(posedge clk) disable iff (!nrst)
		!tick && !wr |=> count_value == $past(count_value)) else $error("count moved without tick");
	pin_override_a: assert property (@(posedge clk) disable iff (!nrst)
		output_mode_a == 2'd0 |=> wave_out_a == $past(port_data_a)) else $error("pin taken in mode 0");
	fast_b_off_a: assert property (@(posedge clk) disable iff (!nrst)
		kind == DSPW_KIND_FAST && output_mode_b == 2'd1 |=> wave_out_b == $past(port_data_b))
		else $error("output b driven in fast toggle mode");
	cover_reverse_c: cover property (@(posedge clk) disable iff (!nrst) kind == DSPW_KIND_DUAL && tick && at_top);
	cover_bottom_c: cover property (@(posedge clk) disable iff (!nrst) waveform_mode == 4'd9 && bottom_load);
	cover_match_c: cover property (@(posedge clk) disable iff (!nrst) match_a && down);
endmodule : dspw_timer
`default_nettype wire

// >>> verif/dspw_pin_model.sv
// Purpose: Port pin with the external load
// Assumes: One clock
// Notes:   Undriven pin shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module dspw_pin_model (
	input  wire logic clk,
	input  wire logic drv,
	input  wire logic oe,
	output logic      pin
);
	logic last = 1'b0;
	always_ff @(posedge clk) begin
		if (oe) last <= drv;
	end
	// No pull on the line, so never let a stale level pass
	assign pin = oe ? drv : ~last;
endmodule : dspw_pin_model
`default_nettype wire

// >>> verif/dual_slope_timer_pwm_outputs_tb_top.sv
// Purpose: Self-checking bench for the dual-slope PWM timer
// Assumes: Tick every clk (clock select 1), except in the divide-by-8 count check
// Notes:   Duty is measured over whole periods, so phase does not matter
`timescale 1ns/1ps
`default_nettype none
`include "dspw_defines.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin bad_count++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module dual_slope_timer_pwm_outputs_tb_top;
	logic       clk = 1'b0;
	logic       nrst = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       dir_a = 1'b1;
	logic       dir_b = 1'b1;
	logic       pd_a = 1'b0;
	logic       pd_b = 1'b0;
	logic [7:0] rdata, v;
	logic       out_a, out_b, oe_a, oe_b, pin_a, pin_b;
	logic [7:0] q[$];
	int         bad_count = 0;
	int         checks_done = 0;
	int         seed = 32'h5B6BAF96;
	int         ha, hb, m, c, e;

	dspw_timer dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.pin_direction_a(dir_a), .pin_direction_b(dir_b), .port_data_a(pd_a), .port_data_b(pd_b),
		.wave_out_a(out_a), .wave_out_b(out_b), .wave_oe_a(oe_a), .wave_oe_b(oe_b));
	dspw_pin_model pa (.clk(clk), .drv(out_a), .oe(oe_a), .pin(pin_a));
	dspw_pin_model pb (.clk(clk), .drv(out_b), .oe(oe_b), .pin(pin_b));

	always #2 clk = ~clk;

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic wr8(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr8

	task automatic wr16(input logic [3:0] a, input int d);
		wr8(a + 4'h1, d[15:8]);
		wr8(a, d[7:0]);
	endtask : wr16

	task automatic rd8(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd8

	// Compares load at once in mode 0, so TOP never starts stale
	task automatic cfg(input int w, input int ma, input int mb, input int top, input int ca, input int cb);
		wr8(`DSPW_ADDR_CTRL_B, 8'h00);
		wr8(`DSPW_ADDR_CTRL_A, 8'h00);
		wr16(`DSPW_ADDR_CMPA_LO, ca);
		wr16(`DSPW_ADDR_CMPB_LO, cb);
		wr16(`DSPW_ADDR_CAP_LO, top);
		wr16(`DSPW_ADDR_CNT_LO, 0);
		wr8(`DSPW_ADDR_FLAGS, 8'h0F);
		wr8(`DSPW_ADDR_CTRL_A, 8'((ma << 6) | (mb << 4) | (w & 3)));
		wr8(`DSPW_ADDR_CTRL_B, 8'(((w >> 2) << 3) | 1));
		repeat (6 * top + 8) @(posedge clk);
	endtask : cfg

	task automatic wave(input int n, input int ea, input int eb);
		ha = 0;
		hb = 0;
		repeat (n) begin
			@(posedge clk);
			#1;
			ha += pin_a;
			hb += pin_b;
		end
		`CHK("high_a", ea, ha)
		`CHK("high_b", eb, hb)
	endtask : wave

	// Back-to-back reads; each count must follow the dual-slope walk
	task automatic seq(input int w, input int top);
		cfg(w, 0, 0, top, (w == 9) ? top : 0, {$random(seed)} % (top + 1));
		q.delete();
		repeat (4 * top + 2) begin
			@(posedge clk);
			addr <= `DSPW_ADDR_CNT_LO;
			rd   <= 1'b1;
			#1 q.push_back(rdata);
		end
		@(posedge clk);
		rd <= 1'b0;
		for (int i = 3; i < q.size(); i++) begin
			m = (q[i-1] == top) ? top - 1 : (q[i-1] == 0) ? 1 : 2 * q[i-1] - q[i-2];
			`CHK("count", 8'(m), q[i])
		end
		wr8(`DSPW_ADDR_CTRL_B, 8'h00);
		rd8(`DSPW_ADDR_FLAGS, v);
		`CHK("flags", (w == 8) ? 8'h0F : 8'h07, v)
		wr8(`DSPW_ADDR_FLAGS, 8'h0F);
		rd8(`DSPW_ADDR_FLAGS, v);
		`CHK("flags_clr", 8'h00, v)
	endtask : seq

	task automatic results();
		if (bad_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		#100000;
		bad_count++;
		results();
	end

	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd8(`DSPW_ADDR_CTRL_A, v);
		`CHK("ctrl_a", `DSPW_CTRL_A_RESET, v)
		wr8(`DSPW_ADDR_CTRL_A, 8'h0C);
		rd8(`DSPW_ADDR_CTRL_A, v);
		`CHK("ctrl_a_force", 8'h00, v)
		rd8(4'hF, v);
		`CHK("unmapped", 8'h00, v)
		seq(9, 3 + {$random(seed)} % 18);
		seq(8, 3 + {$random(seed)} % 18);
		// Divide by 8: ticks land 9, 17, ... cycles after the select write
		wr16(`DSPW_ADDR_CNT_LO, 0);
		wr8(`DSPW_ADDR_CTRL_B, 8'h02);
		repeat (80) @(posedge clk);
		rd8(`DSPW_ADDR_CNT_LO, v);
		`CHK("count_div8", 8'd10, v)
		for (m = 2; m < 4; m++) begin
			for (c = 0; c < 9; c += 4) begin
				cfg(9, 0, m, 8, 8, c);
				wave(16, 0, (m == 2) ? 2 * c : 16 - 2 * c);
			end
		end
		cfg(9, 1, 1, 8, 8, 3);
		wave(32, 16, 0);
		cfg(8, 1, 0, 8, 3, 3);
		wave(32, 0, 0);
		for (m = 2; m < 4; m++) begin
			for (c = 1; c < 6; c += 4) begin
				cfg(14, 0, m, 5, 0, c);
				e = (m == 2) ? ((c == 5) ? 12 : 2 * (c + 1)) : ((c == 5) ? 0 : 2 * (5 - c));
				wave(12, 0, e);
			end
		end
		cfg(15, 1, 1, 5, 5, 2);
		wave(24, 12, 0);
		for (m = 1; m < 4; m++) begin
			cfg(4, 0, m, 5, 5, 2);
			wave(12, 0, (m == 1) ? 6 : (m == 2) ? 0 : 12);
		end
		cfg(0, 0, 0, 5, 5, 2);
		repeat (8) begin
			@(posedge clk);
			{pd_a, pd_b} <= 2'($random(seed));
			@(posedge clk);
			#1 `CHK("port_b", pd_b, out_b)
			`CHK("port_a", pd_a, out_a)
			`CHK("oe_on", 2'b11, {oe_a, oe_b})
		end
		@(posedge clk);
		{dir_a, dir_b} <= 2'b00;
		repeat (2) @(posedge clk);
		#1 `CHK("oe_b", 1'b0, oe_b)
		`CHK("oe_a", 1'b0, oe_a)
		results();
	end
endmodule : dual_slope_timer_pwm_outputs_tb_top
`default_nettype wire
